// File: rtl/lcm_defines.svh
`ifndef LCM_DEFINES_SVH
`define LCM_DEFINES_SVH

`define LCM_TASK_COMPLETE   8'h00
`define LCM_EXTENDED        8'h01
`define LCM_SAVE_PTR        8'h02
`define LCM_RESTORE_PTR     8'h03
`define LCM_DISCONNECT      8'h04
`define LCM_INIT_DET_ERR    8'h05
`define LCM_REJECT          8'h07
`define LCM_NO_OP           8'h08
`define LCM_PARITY_ERR      8'h09
`define LCM_CONTINUE_TASK   8'h12
`define LCM_XFER_DISABLE    8'h13
`define LCM_ABORT_TAG       8'h0d
`define LCM_IDENTIFY_BIT    7
`define LCM_CLK_NS          25
`define LCM_DISC_DELAY_NS   200
`define LCM_DISC_DELAY_CYC  ((`LCM_DISC_DELAY_NS + `LCM_CLK_NS - 1) / `LCM_CLK_NS)

`endif

// File: rtl/lcm_initiator.sv
`timescale 1ns/1ps
`include "lcm_defines.svh"
module lcm_initiator
    import lcm_pkg::*;
(
    input  wire logic       ref_clk,     // clock
    input  wire logic       resetn,      // async reset, low
    input  wire logic       clk_en,      // freezes state when low
    lcm_link_if.initiator   link,        // message link
    input  wire logic [7:0] send_code,   // byte to send
    input  wire logic       send_last,   // byte ends the message
    input  wire logic       send_valid,  // send request, pulse
    input  wire logic       is_reselect, // selection is a reconnection
    input  wire logic       refuse_disc, // reject target disconnect
    output logic            send_ready,  // may send
    output logic [7:0]      got_code,    // received byte
    output logic            got_valid,   // got_code new, pulse
    output logic            ptr_saved,   // data pointer saved, pulse
    output logic            target_gone  // target released bus
);
    logic rej_pend_r;
    logic abort_pend_r;
    logic [7:0] ob_r;
    logic ob_v_r;
    logic atn_r;
    logic mia_r;

    assign link.ini_byte   = ob_r;
    assign link.ini_ack    = ob_v_r;
    assign link.atn        = atn_r;
    assign link.msg_in_ack = mia_r;
    assign link.reselect   = is_reselect;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ob_r <= 8'h00; ob_v_r <= 1'b0; atn_r <= 1'b0; mia_r <= 1'b0;
            rej_pend_r <= 1'b0; abort_pend_r <= 1'b0; send_ready <= 1'b1;
            got_code <= 8'h00; got_valid <= 1'b0; ptr_saved <= 1'b0; target_gone <= 1'b0;
        end else if (clk_en) begin
            ob_v_r <= 1'b0; mia_r <= 1'b0; got_valid <= 1'b0; ptr_saved <= 1'b0;
            target_gone <= !link.bsy;
            if (link.tgt_req) begin
                got_code  <= link.tgt_byte;
                got_valid <= 1'b1;
                mia_r     <= 1'b1;
                if (link.tgt_byte == `LCM_SAVE_PTR)
                    ptr_saved <= 1'b1;
                if (link.tgt_byte == `LCM_DISCONNECT && refuse_disc) begin
                    atn_r      <= 1'b1;
                    rej_pend_r <= 1'b1;
                end
                if (link.tgt_byte == `LCM_REJECT && ob_r == `LCM_CONTINUE_TASK) begin
                    atn_r        <= 1'b1;
                    abort_pend_r <= 1'b1;
                end
            end else if (rej_pend_r) begin
                ob_r <= `LCM_REJECT; ob_v_r <= 1'b1; atn_r <= 1'b0; rej_pend_r <= 1'b0;
            end else if (abort_pend_r) begin
                ob_r <= `LCM_ABORT_TAG; ob_v_r <= 1'b1; atn_r <= 1'b0; abort_pend_r <= 1'b0;
            end else if (send_valid) begin
                ob_r   <= send_code;
                ob_v_r <= 1'b1;
                atn_r  <= !send_last;
            end
            send_ready <= !rej_pend_r && !abort_pend_r;
        end
    end
endmodule : lcm_initiator

// File: rtl/lcm_link_if.sv
`timescale 1ns/1ps
interface lcm_link_if;
    logic [7:0] tgt_byte;    // target to initiator message byte
    logic       tgt_req;     // target byte valid, pulse
    logic [7:0] ini_byte;    // initiator to target message byte
    logic       ini_ack;     // initiator byte valid, pulse
    logic       atn;         // initiator attention level
    logic       msg_in_ack;  // initiator took target byte, pulse
    logic       bsy;         // target holds bus
    logic       reselect;    // initiator selection is a reconnection
    modport target (output tgt_byte, output tgt_req, output bsy, input ini_byte,
                    input ini_ack, input atn, input msg_in_ack, input reselect);
    modport initiator (input tgt_byte, input tgt_req, input bsy, output ini_byte,
                       output ini_ack, output atn, output msg_in_ack, output reselect);
endinterface : lcm_link_if

// File: rtl/lcm_msg_decoder.sv
`timescale 1ns/1ps
`include "lcm_defines.svh"
module lcm_msg_decoder
    import lcm_pkg::*;
(
    input  wire logic [7:0] code,      // first message byte
    output lcm_fmt_e        fmt,       // message format
    output logic            known_out  // supported initiator-to-target one-byte code
);
    always_comb begin
        known_out = 1'b0;
        if (code[`LCM_IDENTIFY_BIT]) begin
            fmt = LCM_FMT_IDFY;
        end else if (code == `LCM_EXTENDED) begin
            fmt = LCM_FMT_EXT;
        end else begin
            fmt = LCM_FMT_ONE;
            if (code == `LCM_INIT_DET_ERR || code == `LCM_PARITY_ERR || code == `LCM_NO_OP)
                known_out = 1'b1;
            if (code == `LCM_REJECT || code == `LCM_XFER_DISABLE)
                known_out = 1'b1;
        end
    end
endmodule : lcm_msg_decoder

// File: rtl/lcm_pkg.sv
package lcm_pkg;
    typedef logic [7:0] lcm_byte_t;
    typedef enum logic [2:0] {
        LCM_FMT_ONE  = 3'h1,
        LCM_FMT_EXT  = 3'h2,
        LCM_FMT_IDFY = 3'h4
    } lcm_fmt_e;
endpackage : lcm_pkg

// File: rtl/lcm_target.sv
`timescale 1ns/1ps
`include "lcm_defines.svh"
module lcm_target
    import lcm_pkg::*;
#(
    parameter logic [15:0] DISC_LIMIT_CYC = 16'h0000
) (
    input  wire logic       ref_clk,        // clock
    input  wire logic       resetn,         // async reset, low
    input  wire logic       clk_en,         // freezes state when low
    lcm_link_if.target      link,           // message link
    input  wire logic       connect,        // new nexus starts, pulse
    input  wire logic       reconnect,      // nexus is a reconnection
    input  wire logic       disc_supported, // initiator disconnect allowed
    input  wire logic       cont_accept,    // continue taken as head of queue
    input  wire logic       seg_done,       // data segment ends, pulse
    input  wire logic       send_complete,  // send task complete, pulse
    input  wire logic       send_restore,   // send restore pointers, pulse
    output logic            bus_free,       // bus released, pulse
    output logic            head_of_queue,  // head of queue request, pulse
    output logic            arb_allowed,    // may arbitrate again
    output logic [7:0]      rx_code,        // last received code
    output logic            rx_valid,       // rx_code new, pulse
    output logic            reconn_fault    // reject not followed by abort
);
    typedef enum logic [5:0] {
        LCM_ST_IDLE  = 6'h01,
        LCM_ST_SAVE  = 6'h02,
        LCM_ST_DISC  = 6'h04,
        LCM_ST_WAIT  = 6'h08,
        LCM_ST_REJ   = 6'h10,
        LCM_ST_EXT   = 6'h20
    } lcm_tst_e;

    lcm_tst_e   st_r;
    lcm_fmt_e   fmt;
    logic       known;
    logic       reconn_r;
    logic       rej_cont_r;
    logic [8:0] ext_left_r;
    logic [15:0] hold_r;
    logic [7:0] tx_r;
    logic       tx_v_r;

    localparam logic [15:0] HOLD_CYC = (16'(`LCM_DISC_DELAY_CYC) > DISC_LIMIT_CYC) ?
                                       16'(`LCM_DISC_DELAY_CYC) : DISC_LIMIT_CYC;

    lcm_msg_decoder u_dec (
        .code      (link.ini_byte),
        .fmt       (fmt),
        .known_out (known)
    );

    function automatic logic first_byte(input lcm_tst_e s);
        first_byte = (s != LCM_ST_EXT);
    endfunction : first_byte

    assign link.tgt_byte = tx_r;
    assign link.tgt_req  = tx_v_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reconn_r <= 1'b0;
        end else if (clk_en && connect) begin
            reconn_r <= reconnect;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_code  <= 8'h00;
            rx_valid <= 1'b0;
        end else if (clk_en) begin
            rx_valid <= link.ini_ack;
            if (link.ini_ack)
                rx_code <= link.ini_byte;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ext_left_r <= 9'h000;
        end else if (clk_en && link.ini_ack) begin
            // 1ff waits for the length byte; length 0 means 256 bytes follow
            if (st_r == LCM_ST_IDLE && fmt == LCM_FMT_EXT)
                ext_left_r <= 9'h1ff;
            else if (st_r == LCM_ST_EXT && ext_left_r == 9'h1ff)
                ext_left_r <= (link.ini_byte == 8'h00) ? 9'h100 : {1'b0, link.ini_byte};
            else if (st_r == LCM_ST_EXT && ext_left_r != 9'h000)
                ext_left_r <= ext_left_r - 9'h001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hold_r      <= 16'h0000;
            arb_allowed <= 1'b1;
        end else if (clk_en) begin
            if (st_r == LCM_ST_WAIT && link.msg_in_ack && !link.atn) begin
                hold_r      <= HOLD_CYC - 16'h0001;
                arb_allowed <= 1'b0;
            end else if (hold_r != 16'h0000) begin
                hold_r <= hold_r - 16'h0001;
            end else begin
                arb_allowed <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r          <= LCM_ST_IDLE;
            tx_r          <= 8'h00;
            tx_v_r        <= 1'b0;
            link.bsy      <= 1'b0;
            bus_free      <= 1'b0;
            head_of_queue <= 1'b0;
            rej_cont_r    <= 1'b0;
            reconn_fault  <= 1'b0;
        end else if (clk_en) begin
            tx_v_r        <= 1'b0;
            bus_free      <= 1'b0;
            head_of_queue <= 1'b0;
            if (connect) begin
                link.bsy     <= 1'b1;
                reconn_fault <= 1'b0;
            end
            case (st_r)
                LCM_ST_IDLE: begin
                    if (link.ini_ack && first_byte(st_r)) begin
                        if (rej_cont_r) begin
                            rej_cont_r <= 1'b0;
                            if (link.ini_byte != `LCM_ABORT_TAG)
                                reconn_fault <= 1'b1;
                        end
                        if (fmt == LCM_FMT_EXT) begin
                            st_r <= LCM_ST_EXT;
                        end else if (link.ini_byte == `LCM_CONTINUE_TASK) begin
                            if (!reconn_r) begin
                                link.bsy <= 1'b0;
                                bus_free <= 1'b1;
                            end else if (cont_accept) begin
                                head_of_queue <= 1'b1;
                            end else begin
                                tx_r       <= `LCM_REJECT;
                                tx_v_r     <= 1'b1;
                                rej_cont_r <= 1'b1;
                            end
                        end else if (link.ini_byte == `LCM_DISCONNECT) begin
                            if (disc_supported) begin
                                tx_r   <= `LCM_SAVE_PTR;
                                tx_v_r <= 1'b1;
                                st_r   <= LCM_ST_SAVE;
                            end else begin
                                tx_r   <= `LCM_REJECT;
                                tx_v_r <= 1'b1;
                            end
                        end else if (fmt == LCM_FMT_ONE && !known
                                     && link.ini_byte != `LCM_ABORT_TAG) begin
                            tx_r   <= `LCM_REJECT;
                            tx_v_r <= 1'b1;
                        end
                    end else if (seg_done && link.bsy) begin
                        tx_r   <= `LCM_SAVE_PTR;
                        tx_v_r <= 1'b1;
                        st_r   <= LCM_ST_SAVE;
                    end else if (send_complete) begin
                        tx_r   <= `LCM_TASK_COMPLETE;
                        tx_v_r <= 1'b1;
                    end else if (send_restore) begin
                        tx_r   <= `LCM_RESTORE_PTR;
                        tx_v_r <= 1'b1;
                    end
                end
                LCM_ST_SAVE: begin
                    if (link.msg_in_ack) begin
                        tx_r   <= `LCM_DISCONNECT;
                        tx_v_r <= 1'b1;
                        st_r   <= LCM_ST_WAIT;
                    end
                end
                LCM_ST_WAIT: begin
                    if (link.msg_in_ack && !link.atn) begin
                        link.bsy <= 1'b0;
                        bus_free <= 1'b1;
                        st_r     <= LCM_ST_IDLE;
                    end else if (link.msg_in_ack) begin
                        st_r <= LCM_ST_REJ;
                    end
                end
                LCM_ST_REJ: begin
                    if (link.ini_ack)
                        st_r <= LCM_ST_IDLE;
                end
                LCM_ST_EXT: begin
                    if (link.ini_ack && ext_left_r == 9'h001)
                        st_r <= LCM_ST_IDLE;
                end
                default: st_r <= LCM_ST_IDLE;
            endcase
        end
    end
endmodule : lcm_target

// File: testbench/lcm_link_assertions.sv
`timescale 1ns/1ps
module lcm_link_assertions (
    input wire logic       ref_clk,    // clock
    input wire logic       resetn,     // async reset, low
    input wire logic [7:0] tgt_byte,   // target byte
    input wire logic       tgt_req,    // target byte valid
    input wire logic [7:0] ini_byte,   // initiator byte
    input wire logic       ini_ack,    // initiator byte valid
    input wire logic       atn,        // attention
    input wire logic       msg_in_ack, // target byte taken
    input wire logic       bsy,        // target holds bus
    input wire logic       reselect    // reconnection
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence disc_sent;
        tgt_req && tgt_byte == 8'h04 ##1 msg_in_ack;
    endsequence
    disc_release_a: assert property (disc_sent ##0 !atn |=> !bsy)
        else $error("bus kept after disconnect");
    disc_refused_a: assert property (disc_sent ##0 atn |=> bsy)
        else $error("bus dropped with attention up");
    ini_disc_a: assert property (ini_ack && ini_byte == 8'h04 && bsy
        |=> tgt_req && tgt_byte inside {8'h02, 8'h07}) else $error("bad disconnect answer");
    save_then_disc_a: assert property (tgt_req && tgt_byte == 8'h02
        |=> msg_in_ack ##1 tgt_req && tgt_byte == 8'h04) else $error("save not followed");
    cont_initial_a: assert property (ini_ack && ini_byte == 8'h12 && !reselect
        |-> ##[1:2] !bsy) else $error("continue on new nexus kept bus");
    cont_reconn_a: assert property (ini_ack && ini_byte == 8'h12 && reselect
        |=> bsy [*2]) else $error("continue on reconnection dropped bus");
    no_reject_a: assert property (ini_ack && ini_byte inside {8'h05, 8'h08, 8'h09, 8'h13}
        |=> !(tgt_req && tgt_byte == 8'h07)) else $error("supported code rejected");
    unknown_reject_a: assert property (ini_ack && ini_byte inside {[8'h18:8'h1f]} && bsy
        |=> tgt_req && tgt_byte == 8'h07) else $error("reserved code not rejected");
    identify_ok_a: assert property (ini_ack && ini_byte[7]
        |=> !(tgt_req && tgt_byte == 8'h07)) else $error("identify rejected");
    idle_quiet_a: assert property (!bsy |-> !tgt_req)
        else $error("byte sent without bus");
    ack_cause_a: assert property (msg_in_ack |-> $past(tgt_req))
        else $error("take without target byte");
    cover property (disc_sent ##1 !bsy);
    cover property (ini_ack && ini_byte == 8'h12 && reselect);
    cover property (tgt_req && tgt_byte == 8'h07);
endmodule : lcm_link_assertions

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int HOLD = 12; // max of 8 delay cycles and limit 12
    logic ref_clk = 0, resetn = 0, clk_en = 1, connect = 0, reconnect = 0;
    logic disc_supported = 1, cont_accept = 0, seg_done = 0, send_complete = 0;
    logic send_restore = 0, send_last = 1, send_valid = 0, is_reselect = 0, refuse_disc = 0;
    logic [7:0] send_code = 0, c;
    logic bus_free, head_of_queue, arb_allowed, rx_valid, reconn_fault;
    logic send_ready, got_valid, ptr_saved, target_gone;
    logic [7:0] rx_code, got_code;
    logic [31:0] seed, r;
    logic [7:0] eq[$], rq[$];
    logic [7:0] codes[4] = '{8'h05, 8'h09, 8'h08, 8'h13};
    logic [7:0] ext_msg[5] = '{8'h01, 8'h03, 8'h01, 8'h0c, 8'h0b};
    int failures = 0, n_tests = 0, cyc = 0, n_free = 0, n_hoq = 0, n_ptr = 0, n_arb = 0, a0;
    lcm_link_if link ();
    lcm_target #(.DISC_LIMIT_CYC(16'h000c)) u_lcm_target (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .link(link.target),
        .connect(connect), .reconnect(reconnect), .disc_supported(disc_supported),
        .cont_accept(cont_accept), .seg_done(seg_done), .send_complete(send_complete),
        .send_restore(send_restore), .bus_free(bus_free), .head_of_queue(head_of_queue),
        .arb_allowed(arb_allowed), .rx_code(rx_code), .rx_valid(rx_valid),
        .reconn_fault(reconn_fault));
    lcm_initiator u_lcm_initiator (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .link(link.initiator),
        .send_code(send_code), .send_last(send_last), .send_valid(send_valid),
        .is_reselect(is_reselect), .refuse_disc(refuse_disc), .send_ready(send_ready),
        .got_code(got_code), .got_valid(got_valid), .ptr_saved(ptr_saved),
        .target_gone(target_gone));
    lcm_link_assertions u_lcm_link_assertions (
        .ref_clk(ref_clk), .resetn(resetn), .tgt_byte(link.tgt_byte), .tgt_req(link.tgt_req),
        .ini_byte(link.ini_byte), .ini_ack(link.ini_ack), .atn(link.atn),
        .msg_in_ack(link.msg_in_ack), .bsy(link.bsy), .reselect(link.reselect));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic gap(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : gap
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 50 && send_ready !== 1'b1; i++) gap(1);
        send_code = b;
        send_valid = 1'b1;
        gap(1);
        send_valid = 1'b0;
        gap(8);
    endtask : send
    task automatic open_nexus(input logic re);
        reconnect = re;
        is_reselect = re;
        connect = 1'b1;
        gap(1);
        connect = 1'b0;
        gap(2);
    endtask : open_nexus
    // model of expected target bytes and received codes; target bytes checked at every pulse, received codes only while rq is not empty
    always @(negedge ref_clk) begin
        if (resetn) begin
            if (got_valid === 1'b1)
                chk("got_code", {1'b0, got_code}, eq.size() ? {1'b0, eq.pop_front()} : 9'h1ff);
            if (rx_valid === 1'b1 && rq.size())
                chk("rx_code", {1'b0, rx_code}, {1'b0, rq.pop_front()});
            n_free += int'(bus_free === 1'b1);
            n_hoq += int'(head_of_queue === 1'b1);
            n_ptr += int'(ptr_saved === 1'b1);
            n_arb += int'(arb_allowed === 1'b0);
            cyc++;
            if (cyc == 4000) begin
                failures++;
                conclude();
            end
        end
    end
    initial begin
        seed = 32'hae2f;
        gap(16);
        resetn = 1'b1;
        gap(2);
        open_nexus(1'b0);
        foreach (codes[i]) begin
            rq.push_back(codes[i]);
            send(codes[i]);
        end
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            c = 8'h80 | r[7:0];
            rq.push_back(c);
            send(c);
            eq.push_back(8'h07);
            send(8'h18 | {5'h00, r[10:8]});
        end
        foreach (ext_msg[i]) begin
            send_last = (i == 4);
            rq.push_back(ext_msg[i]);
            send(ext_msg[i]);
            if (i == 3) chk("atn_mid", {8'h00, link.atn}, 9'h001);
        end
        chk("atn_end", {8'h00, link.atn}, 9'h000);
        eq.push_back(8'h07);
        send(8'h19);
        send_restore = 1'b1;
        eq.push_back(8'h03);
        gap(1);
        send_restore = 1'b0;
        gap(8);
        send_complete = 1'b1;
        eq.push_back(8'h00);
        gap(1);
        send_complete = 1'b0;
        clk_en = 1'b0;
        gap(5);
        chk("frz_req", {8'h00, link.tgt_req}, 9'h001);
        clk_en = 1'b1;
        gap(8);
        open_nexus(1'b0);
        refuse_disc = 1'b1;
        eq = '{8'h02, 8'h04};
        rq.push_back(8'h07);
        seg_done = 1'b1;
        gap(1);
        seg_done = 1'b0;
        gap(14);
        chk("bsy_refused", {8'h00, link.bsy}, 9'h001);
        refuse_disc = 1'b0;
        eq = '{8'h02, 8'h04};
        seg_done = 1'b1;
        gap(1);
        seg_done = 1'b0;
        gap(30);
        chk("seg_free", 9'(n_free), 9'h001);
        chk("ptr_saved", 9'(n_ptr), 9'h002);
        chk("target_gone", {8'h00, target_gone}, 9'h001);
        open_nexus(1'b0);
        a0 = n_arb;
        eq = '{8'h02, 8'h04};
        send(8'h04);
        gap(30);
        chk("ini_free", 9'(n_free), 9'h002);
        chk("arb_hold", 9'(n_arb - a0), 9'(HOLD));
        disc_supported = 1'b0;
        open_nexus(1'b0);
        eq.push_back(8'h07);
        send(8'h04);
        chk("bsy_kept", {8'h00, link.bsy}, 9'h001);
        disc_supported = 1'b1;
        send(8'h12);
        gap(4);
        chk("cont_free", 9'(n_free), 9'h003);
        open_nexus(1'b1);
        cont_accept = 1'b1;
        rq.push_back(c);
        send(c);
        send(8'h12);
        chk("head_queue", 9'(n_hoq), 9'h001);
        cont_accept = 1'b0;
        eq.push_back(8'h07);
        send(8'h12);
        send(8'h0d);
        chk("reconn_fault", {8'h00, reconn_fault}, 9'h000);
        gap(4);
        chk("got_left", 9'(eq.size()), 9'h000);
        chk("rx_left", 9'(rq.size()), 9'h000);
        conclude();
    end
endmodule : tb_top
